// ===== design/counter_preset_map.vh
// Constants for the external preset block
`ifndef COUNTER_PRESET_MAP_VH
`define COUNTER_PRESET_MAP_VH
`define CNT_WIDTH        32
`define CNT_RESET        32'h00000000
`define LOAD_RESET       32'h00000000
`define SRC_PRESET_ONLY  1'b0
`define SRC_ZERO_MARK    1'b1
`define MODE_SINGLE      1'b0
`define MODE_MULTIPLE    1'b1
`define DIR_UP           1'b1
`define DIR_DOWN         1'b0
`define SYNC_STAGES      2
`endif

// ===== design/edge_sync.v
// Two-stage synchroniser with a rising-edge pulse
`include "counter_preset_map.vh"
module edge_sync (
    input  wire clk_sys,
    input  wire reset,
    input  wire din,
    output reg  level,
    output wire rise
);
    reg meta;
    reg last;

    // First stage feeds only the second stage
    always @(posedge clk_sys) begin
        if (reset) begin
            meta  <= 1'b0;
            level <= 1'b0;
            last  <= 1'b0;
        end else begin
            meta  <= din;
            level <= meta;
            last  <= level;
        end
    end

    assign rise = level & ~last;
endmodule

// ===== design/counter_external_preset.v
// External preset logic of a counting module
`include "counter_preset_map.vh"
module counter_external_preset (
    input  wire                   clk_sys,
    input  wire                   reset,
    input  wire [`CNT_WIDTH-1:0]  loadValue,
    input  wire                   prepareLoadCmd,
    input  wire                   directLoadCmd,
    input  wire                   signedRange,
    input  wire                   presetSource,
    input  wire                   presetMode,
    input  wire                   presetUpEnable,
    input  wire                   presetDownEnable,
    input  wire                   syncClearCmd,
    input  wire                   presetIrqEnable,
    input  wire                   gateOpen,
    input  wire                   countUp,
    input  wire                   countStep,
    input  wire                   presetInput,
    input  wire                   zeroMark,
    output reg  [`CNT_WIDTH-1:0]  count,
    output reg  [`CNT_WIDTH-1:0]  preparedValue,
    output reg                    countNegative,
    output reg                    syncDoneFlag,
    output reg                    presetIrq,
    output reg                    presetLoaded,
    output reg                    directionFrozen
);
    wire presetLevel;
    wire presetRise;
    wire zeroLevel;
    wire zeroRise;
    reg  lastDir;
    reg  upEnPrev;
    reg  downEnPrev;
    reg  [1:0]            armState;
    reg  [1:0]            next_armState;
    wire                  armed;
    wire                  effDir;
    wire                  dirMatch;
    reg                   trigger;
    wire                  enRise;
    wire                  doLoad;
    reg  [`CNT_WIDTH-1:0] next_count;

    // Single mode arm states, one-hot
    localparam [1:0] ARM_IDLE  = 2'b01;
    localparam [1:0] ARM_READY = 2'b10;

    edge_sync u_edge_sync_preset (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     (presetInput),
        .level   (presetLevel),
        .rise    (presetRise)
    );

    edge_sync u_edge_sync_zero (
        .clk_sys (clk_sys),
        .reset   (reset),
        .din     (zeroMark),
        .level   (zeroLevel),
        .rise    (zeroRise)
    );

    // Sign of the count depends on range; counting itself is range agnostic
    function isNegative;
        input [`CNT_WIDTH-1:0] v;
        input                  sgn;
        begin
            isNegative = sgn & v[`CNT_WIDTH-1];
        end
    endfunction

    // Direction is only tracked while gate open; closed gate holds it
    assign effDir = gateOpen ? countUp : lastDir;

    // No enable means no match, so all events fall through
    assign dirMatch = (presetUpEnable & (effDir == `DIR_UP))
        | (presetDownEnable & (effDir == `DIR_DOWN));

    // Count mode plays no part in the trigger path
    always @* begin
        case (presetSource)
            `SRC_ZERO_MARK: begin
                trigger = zeroRise & presetLevel;
            end
            `SRC_PRESET_ONLY: begin
                trigger = presetRise;
            end
            default: begin
                trigger = 1'b0;
            end
        endcase
    end

    // Either enable rising re-arms single mode
    assign enRise = (presetUpEnable & ~upEnPrev)
        | (presetDownEnable & ~downEnPrev);

    assign doLoad = trigger & dirMatch
        & ((presetMode == `MODE_MULTIPLE) | armed);

    assign armed = (armState == ARM_READY);

    // Priority: direct load, then external preset, then counting
    always @* begin
        next_count = count;
        if (directLoadCmd) begin
            next_count = loadValue;
        end else if (doLoad) begin
            next_count = preparedValue;
        end else if (countStep & gateOpen) begin
            if (countUp == `DIR_UP) begin
                next_count = count + 32'h00000001;
            end else begin
                next_count = count - 32'h00000001;
            end
        end
    end

    // Counter register
    always @(posedge clk_sys) begin
        if (reset) begin
            count <= `CNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // Prepared value kept apart so counting never disturbs it
    always @(posedge clk_sys) begin
        if (reset) begin
            preparedValue <= `LOAD_RESET;
        end else if (prepareLoadCmd | directLoadCmd) begin
            preparedValue <= loadValue;
        end
    end

    // Sign flag follows the value that lands in the counter
    always @(posedge clk_sys) begin
        if (reset) begin
            countNegative <= 1'b0;
        end else begin
            countNegative <= isNegative(next_count, signedRange);
        end
    end

    // Direction is sampled only while the gate is open
    always @(posedge clk_sys) begin
        if (reset) begin
            lastDir <= `DIR_UP;
        end else if (gateOpen) begin
            lastDir <= countUp;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            directionFrozen <= 1'b0;
        end else begin
            directionFrozen <= ~gateOpen;
        end
    end

    // Previous enable levels for the re-arm edge detect
    always @(posedge clk_sys) begin
        if (reset) begin
            upEnPrev <= 1'b0;
        end else begin
            upEnPrev <= presetUpEnable;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            downEnPrev <= 1'b0;
        end else begin
            downEnPrev <= presetDownEnable;
        end
    end

    // A load consumes the arm; a fresh enable edge restores it
    always @* begin
        next_armState = armState;
        case (armState)
            ARM_IDLE: begin
                if (enRise & ~doLoad) begin
                    next_armState = ARM_READY;
                end
            end
            ARM_READY: begin
                if (doLoad) begin
                    next_armState = ARM_IDLE;
                end
            end
            default: begin
                next_armState = ARM_IDLE;
            end
        endcase
    end

    // Starts disarmed: an enable must rise after reset
    always @(posedge clk_sys) begin
        if (reset) begin
            armState <= ARM_IDLE;
        end else begin
            armState <= next_armState;
        end
    end

    // Set wins over a clear in the same cycle, so no load is lost
    always @(posedge clk_sys) begin
        if (reset) begin
            syncDoneFlag <= 1'b0;
        end else if (doLoad) begin
            syncDoneFlag <= 1'b1;
        end else if (syncClearCmd) begin
            syncDoneFlag <= 1'b0;
        end
    end

    // One-cycle load strobe
    always @(posedge clk_sys) begin
        if (reset) begin
            presetLoaded <= 1'b0;
        end else begin
            presetLoaded <= doLoad;
        end
    end

    // Interrupt request is a bare pulse; the host must catch it
    always @(posedge clk_sys) begin
        if (reset) begin
            presetIrq <= 1'b0;
        end else begin
            presetIrq <= doLoad & presetIrqEnable;
        end
    end
endmodule

// ===== sim/counter_external_preset_asserts.sv
// Checker of the external preset block
module counter_external_preset_asserts (
    input logic        clk_sys,
    input logic        reset,
    input logic        presetInput,
    input logic        zeroMark,
    input logic        presetSource,
    input logic        presetUpEnable,
    input logic        presetDownEnable,
    input logic        syncClearCmd,
    input logic        presetIrqEnable,
    input logic        prepareLoadCmd,
    input logic        directLoadCmd,
    input logic        gateOpen,
    input logic        signedRange,
    input logic        syncDoneFlag,
    input logic        presetIrq,
    input logic        presetLoaded,
    input logic        directionFrozen,
    input logic        countNegative,
    input logic [31:0] loadValue,
    input logic [31:0] count,
    input logic [31:0] preparedValue
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_load_value: assert property (
        presetLoaded && !$past(directLoadCmd)
        |-> count == $past(preparedValue)) else $error("bad load value");
    chk_sync_set: assert property (
        presetLoaded |-> syncDoneFlag) else $error("sync flag not set");
    chk_sync_hold: assert property (
        syncDoneFlag && !syncClearCmd
        |=> syncDoneFlag) else $error("sync flag dropped");
    chk_irq_cause: assert property (
        presetIrq |-> presetLoaded && $past(presetIrqEnable))
        else $error("stray interrupt");
    chk_no_enable: assert property (
        (!presetUpEnable && !presetDownEnable)[*5]
        |=> !presetLoaded) else $error("load without enable");
    chk_load_cause: assert property (
        presetLoaded
        |-> ($past(presetInput, 3) && !$past(presetInput, 4))
        || ($past(zeroMark, 3) && !$past(zeroMark, 4)))
        else $error("no edge");
    chk_mark_pin: assert property (
        $past(presetSource) && presetLoaded
        |-> $past(presetInput, 3)) else $error("mark load with pin low");
    chk_prep_store: assert property (
        prepareLoadCmd
        |=> preparedValue == $past(loadValue)) else $error("not stored");
    chk_freeze_flag: assert property (
        !$past(reset) |-> directionFrozen == !$past(gateOpen))
        else $error("frozen flag wrong");
    chk_sign_flag: assert property (
        !$past(reset) |-> countNegative == ($past(signedRange) && count[31]))
        else $error("sign flag wrong");
    cover property (presetLoaded && presetSource);
    cover property (presetLoaded && !presetSource);
    cover property (presetIrq);
endmodule
bind counter_external_preset counter_external_preset_asserts u_chk (.*);

// ===== sim/field_model.sv
// Field side: preset input and encoder zero mark
module field_model (
    input  logic clk_sys,
    output logic presetInput = 1'h0,
    output logic zeroMark    = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    task pin(input logic v);
        @(posedge clk_sys) presetInput <= v;
    endtask
    // Held two cycles so the synchroniser cannot miss it
    task mark;
        @(posedge clk_sys) zeroMark <= 1'h1;
        repeat (2) @(posedge clk_sys);
        zeroMark <= 1'h0;
    endtask
endmodule

// ===== sim/test_counter_external_preset.sv
// Self-checking bench of the external preset block
module test_counter_external_preset;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, reset = 1, prepareLoadCmd = 0, directLoadCmd = 0;
    logic presetSource = 0, presetMode = 0, presetUpEnable = 0;
    logic presetDownEnable = 0, syncClearCmd = 0, presetIrqEnable = 0;
    logic gateOpen = 0, countUp = 0, countStep = 0, signedRange = 0;
    logic countNegative, syncDoneFlag, presetIrq, presetLoaded;
    logic directionFrozen, presetInput, zeroMark;
    logic [31:0] loadValue = 0, count, preparedValue, v;
    logic [32:0] exp[$];
    // Bits: source mode up down dirOpen gate dir pin expectLoad
    logic [8:0] steps[22] = '{9'h0DD, 9'h0DD, 9'h0C8, 9'h0A9, 9'h09C,
        9'h0E9, 9'h01C, 9'h05D, 9'h05C, 9'h01C, 9'h05D, 9'h1DF, 9'h1DC,
        9'h1DF, 9'h11E, 9'h15F, 9'h15E, 9'h11C, 9'h15C, 9'h15F, 9'h0D1,
        9'h0C4};
    integer seed = 32'h15E6B66E;
    int mismatches = 0, nCompared = 0;
    counter_external_preset u_counter_external_preset (.*);
    field_model u_field_model (.*);
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) {signedRange, countStep} <= 2'($random(seed));
    task automatic chk(string nm, logic [32:0] seen, want);
        nCompared++;
        if (seen !== want) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(negedge clk_sys) if (presetLoaded !== 1'h0) begin
        if (exp.size() == 0) chk("load", 1, 0);
        else chk("load", {presetIrq, count}, exp.pop_front());
    end
    task step(input logic [8:0] s);
        v = $random(seed);
        @(posedge clk_sys);
        {presetSource, presetMode, presetUpEnable} <= s[8:6];
        {presetDownEnable, countUp} <= s[5:4];
        {loadValue, presetIrqEnable, prepareLoadCmd, gateOpen} <= {v, v[0], 2'h3};
        @(posedge clk_sys) {prepareLoadCmd, gateOpen, countUp} <= {1'h0, s[3:2]};
        if (s[0]) exp.push_back({v[0], v});
        if (s[8]) begin
            u_field_model.pin(s[1]);
            repeat (3) @(posedge clk_sys);
            u_field_model.mark();
        end else u_field_model.pin(1'h1);
        repeat (5) @(posedge clk_sys);
        u_field_model.pin(1'h0);
        repeat (3) @(posedge clk_sys);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 0;
        v = $random(seed);
        @(posedge clk_sys) {directLoadCmd, loadValue} <= {1'h1, v};
        @(posedge clk_sys) directLoadCmd <= 0;
        #1 chk("direct", count, v);
        foreach (steps[i]) step(steps[i]);
        chk("notes", exp.size(), 0);
        chk("sync", syncDoneFlag, 1);
        @(posedge clk_sys) syncClearCmd <= 1;
        @(posedge clk_sys) syncClearCmd <= 0;
        #1 chk("sync", syncDoneFlag, 0);
        end_of_test;
    end
endmodule
